// [shared/lane_config_pkg.sv]
// Purpose: Shared constants for the eight-lane standby and profile configuration block.
// Assumes: APB register access with one 32-bit word per register.
// Notes:   Register indices are kept; the byte address is four times the index.
package lane_config_pkg;

   localparam int unsigned LANES      = 8;
   localparam int unsigned ADDR_W     = 12;
   localparam int unsigned DATA_W     = 32;
   localparam int unsigned RESULT_W   = 16;
   localparam int unsigned HEADER_W   = 8;
   localparam int unsigned TICK_W     = 5;

   // Register indices as numbered in the map, and their byte addresses.
   localparam logic [1:0] IDX_CHANNEL_STANDBY_CONTROL     = 2'h0;
   localparam logic [1:0] IDX_PROFILE_A_FILTER_DECIMATION = 2'h1;
   localparam logic [1:0] IDX_PROFILE_B_FILTER_DECIMATION = 2'h2;
   localparam logic [1:0] IDX_CHANNEL_PROFILE_SELECTOR    = 2'h3;
   localparam logic [ADDR_W-1:0] ADDR_CHANNEL_STANDBY_CONTROL     = 12'h000;
   localparam logic [ADDR_W-1:0] ADDR_PROFILE_A_FILTER_DECIMATION = 12'h004;
   localparam logic [ADDR_W-1:0] ADDR_PROFILE_B_FILTER_DECIMATION = 12'h008;
   localparam logic [ADDR_W-1:0] ADDR_CHANNEL_PROFILE_SELECTOR    = 12'h00C;

   // Values after reset.
   localparam logic [7:0] RST_CHANNEL_STANDBY_CONTROL     = 8'h00;
   localparam logic [3:0] RST_PROFILE_A_FILTER_DECIMATION = 4'hD;
   localparam logic [3:0] RST_PROFILE_B_FILTER_DECIMATION = 4'hD;
   localparam logic [7:0] RST_CHANNEL_PROFILE_SELECTOR    = 8'h00;

   // Profile field layout.
   localparam int unsigned PROFILE_FILTER_BIT = 3;
   localparam int unsigned PROFILE_DEC_MSB    = 2;
   localparam int unsigned PROFILE_W          = 4;

   // Decimation codes; codes above x512 all mean x1024.
   localparam logic [2:0] DEC_X32  = 3'h0;
   localparam logic [2:0] DEC_X64  = 3'h1;
   localparam logic [2:0] DEC_X128 = 3'h2;
   localparam logic [2:0] DEC_X256 = 3'h3;
   localparam logic [2:0] DEC_X512 = 3'h4;

   // Base ticks per result, minus one, as a mask over the tick counter.
   localparam logic [TICK_W-1:0] MASK_X32   = 5'h00;
   localparam logic [TICK_W-1:0] MASK_X64   = 5'h01;
   localparam logic [TICK_W-1:0] MASK_X128  = 5'h03;
   localparam logic [TICK_W-1:0] MASK_X256  = 5'h07;
   localparam logic [TICK_W-1:0] MASK_X512  = 5'h0F;
   localparam logic [TICK_W-1:0] MASK_X1024 = 5'h1F;
   localparam logic [TICK_W-1:0] TICK_RST   = 5'h00;

   // Slot header layout.
   localparam int unsigned HDR_REPEAT_BIT  = 0;
   localparam int unsigned HDR_LANE_LSB    = 1;
   localparam int unsigned HDR_FILTER_BIT  = 4;

endpackage

// [logic/lane_config.sv]
// Purpose: Standby and filter profile registers for eight converter lanes, with the
//          data stream slotting that those settings imply.
// Assumes: APB slave, base_conv_tick pulses once per x32 output period, all inputs
//          synchronous to pclk.
// Notes:   Reads are registered in the setup phase; every access ends after one
//          access cycle.
//
// Contract
// - Each lane enters standby on its own bit, 1 standby and 0 enabled.
// - A standby lane keeps its slot, carrying a zero header and a zero 16-bit result.
// - Standby of lane 0 switches off the common-mode voltage output.
// - Standby of lane 4 switches off the crystal excitation circuitry.
// - Two profiles, A and B, each hold a filter type and a decimation rate for any lane.
// - With mixed rates, data ready follows the fastest decimation in use.
// - A slower lane updates at its own rate, showing zero data and a repeat flag in between.
// - Profile bit 3 picks wideband or sinc5, and bits 2 to 0 pick x32 up to x1024.
// - Selector bit n maps lane n to profile A on 0 and profile B on 1.
// - Profile A resets to 0x0D, sinc5 at x1024.
// - Profile B resets to 0x0D, sinc5 at x1024.
// - The standby register resets to 0x00 with all lanes enabled.
// - The selector resets to 0x00 with every lane on profile A.
`timescale 1ns/1ns
`default_nettype none

module lane_config (
   // Clock and reset
   input  wire  logic                                                     pclk,
   input  wire  logic                                                     presetn,
   // APB slave
   input  wire  logic [lane_config_pkg::ADDR_W-1:0]                       paddr,
   input  wire  logic                                                     psel,
   input  wire  logic                                                     penable,
   input  wire  logic                                                     pwrite,
   input  wire  logic [lane_config_pkg::DATA_W-1:0]                       pwdata,
   input  wire  logic [3:0]                                               pstrb,
   output logic       [lane_config_pkg::DATA_W-1:0]                       prdata,
   output logic                                                           pready,
   output logic                                                           pslverr,
   // Conversion input
   input  wire  logic                                                     base_conv_tick,
   input  wire  logic [lane_config_pkg::LANES-1:0][lane_config_pkg::RESULT_W-1:0] conv_result,
   // Output stream
   output logic                                                           data_ready,
   output logic       [lane_config_pkg::LANES-1:0][lane_config_pkg::HEADER_W-1:0] slot_header,
   output logic       [lane_config_pkg::LANES-1:0][lane_config_pkg::RESULT_W-1:0] slot_data,
   // Analog controls
   output logic                                                           common_mode_voltage_out,
   output logic                                                           crystal_drive_enable,
   output logic       [lane_config_pkg::LANES-1:0]                        lane_filter_sinc5,
   output logic       [lane_config_pkg::LANES-1:0]                        standby_lane
);

   ////////////////////////////////////////////////////////////////////////////////////
   // State.

   typedef struct packed {
      logic [7:0]                                   standby;
      logic [lane_config_pkg::PROFILE_W-1:0]        prof_a;
      logic [lane_config_pkg::PROFILE_W-1:0]        prof_b;
      logic [7:0]                                   pick;
      logic [lane_config_pkg::TICK_W-1:0]           tick_cnt;
      logic                                         drdy;
      logic [lane_config_pkg::LANES-1:0][lane_config_pkg::HEADER_W-1:0] hdr;
      logic [lane_config_pkg::LANES-1:0][lane_config_pkg::RESULT_W-1:0] dat;
      logic [lane_config_pkg::DATA_W-1:0]           rdata;
   } state_type;

   state_type state_r;
   state_type state_nxt;

   ////////////////////////////////////////////////////////////////////////////////////
   // Functions.

   // Nested masks make the fastest rate the AND of the masks in use.
   function automatic logic [lane_config_pkg::TICK_W-1:0] dec_mask(
      input logic [lane_config_pkg::PROFILE_W-1:0] prof
   );
      logic [2:0] code;
      code = prof[lane_config_pkg::PROFILE_DEC_MSB:0];
      case (code)
         lane_config_pkg::DEC_X32:  dec_mask = lane_config_pkg::MASK_X32;
         lane_config_pkg::DEC_X64:  dec_mask = lane_config_pkg::MASK_X64;
         lane_config_pkg::DEC_X128: dec_mask = lane_config_pkg::MASK_X128;
         lane_config_pkg::DEC_X256: dec_mask = lane_config_pkg::MASK_X256;
         lane_config_pkg::DEC_X512: dec_mask = lane_config_pkg::MASK_X512;
         default:                   dec_mask = lane_config_pkg::MASK_X1024;
      endcase
   endfunction

   function automatic logic [lane_config_pkg::PROFILE_W-1:0] lane_profile(
      input state_type                             s,
      input int unsigned                           lane
   );
      lane_profile = s.pick[lane] ? s.prof_b : s.prof_a;
   endfunction

   function automatic logic addr_mapped(
      input logic [lane_config_pkg::ADDR_W-1:0] addr
   );
      addr_mapped = (addr[1:0] == 2'h0) && (addr[lane_config_pkg::ADDR_W-1:4] == '0);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////
   // Next state.

   logic                                 acc_write;
   logic [lane_config_pkg::TICK_W-1:0]   fast_mask;
   logic                                 fast_hit;

   always_comb begin
      logic [1:0]                               idx;
      logic [lane_config_pkg::PROFILE_W-1:0]    prof;
      logic [lane_config_pkg::TICK_W-1:0]       mask;
      idx       = paddr[3:2];
      prof      = '0;
      mask      = '0;
      state_nxt = state_r;
      acc_write = psel && penable && pwrite && addr_mapped(paddr) && pstrb[0];

      // Read data is captured in the setup cycle and stands through the access cycle.
      if (psel && !penable) begin
         state_nxt.rdata = '0;
         if (addr_mapped(paddr)) begin
            case (idx)
               lane_config_pkg::IDX_CHANNEL_STANDBY_CONTROL:
                  state_nxt.rdata[7:0] = state_r.standby;
               lane_config_pkg::IDX_PROFILE_A_FILTER_DECIMATION:
                  state_nxt.rdata[3:0] = state_r.prof_a;
               lane_config_pkg::IDX_PROFILE_B_FILTER_DECIMATION:
                  state_nxt.rdata[3:0] = state_r.prof_b;
               lane_config_pkg::IDX_CHANNEL_PROFILE_SELECTOR:
                  state_nxt.rdata[7:0] = state_r.pick;
               default:
                  state_nxt.rdata = '0;
            endcase
         end
      end

      if (acc_write) begin
         case (idx)
            lane_config_pkg::IDX_CHANNEL_STANDBY_CONTROL:
               state_nxt.standby = pwdata[7:0];
            lane_config_pkg::IDX_PROFILE_A_FILTER_DECIMATION:
               state_nxt.prof_a = pwdata[3:0];
            lane_config_pkg::IDX_PROFILE_B_FILTER_DECIMATION:
               state_nxt.prof_b = pwdata[3:0];
            lane_config_pkg::IDX_CHANNEL_PROFILE_SELECTOR:
               state_nxt.pick = pwdata[7:0];
            default:
               state_nxt.pick = state_r.pick;
         endcase
      end

      // Only lanes that are awake set the pace; all asleep leaves the slowest rate.
      fast_mask = lane_config_pkg::MASK_X1024;
      for (int unsigned n = 0; n < lane_config_pkg::LANES; n++) begin
         if (!state_r.standby[n]) begin
            fast_mask = fast_mask & dec_mask(lane_profile(state_r, n));
         end
      end
      fast_hit = base_conv_tick && ((state_r.tick_cnt & fast_mask) == fast_mask);

      state_nxt.drdy = fast_hit;
      if (base_conv_tick) begin
         state_nxt.tick_cnt = state_r.tick_cnt + 5'h01;
      end

      if (fast_hit) begin
         for (int unsigned n = 0; n < lane_config_pkg::LANES; n++) begin
            prof = lane_profile(state_r, n);
            mask = dec_mask(prof);
            state_nxt.hdr[n] = '0;
            state_nxt.dat[n] = '0;
            if (!state_r.standby[n]) begin
               state_nxt.hdr[n][lane_config_pkg::HDR_LANE_LSB +: 3] = 3'(n);
               state_nxt.hdr[n][lane_config_pkg::HDR_FILTER_BIT] =
                  prof[lane_config_pkg::PROFILE_FILTER_BIT];
               if ((state_r.tick_cnt & mask) == mask) begin
                  state_nxt.dat[n] = conv_result[n];
               end else begin
                  state_nxt.hdr[n][lane_config_pkg::HDR_REPEAT_BIT] = 1'b1;
               end
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r          <= '0;
         state_r.standby  <= lane_config_pkg::RST_CHANNEL_STANDBY_CONTROL;
         state_r.prof_a   <= lane_config_pkg::RST_PROFILE_A_FILTER_DECIMATION;
         state_r.prof_b   <= lane_config_pkg::RST_PROFILE_B_FILTER_DECIMATION;
         state_r.pick     <= lane_config_pkg::RST_CHANNEL_PROFILE_SELECTOR;
         state_r.tick_cnt <= lane_config_pkg::TICK_RST;
      end else begin
         state_r <= state_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // Outputs.

   assign prdata      = state_r.rdata;
   assign pready      = 1'b1;
   assign pslverr     = psel && penable && !addr_mapped(paddr);
   assign data_ready  = state_r.drdy;
   assign slot_header = state_r.hdr;
   assign slot_data   = state_r.dat;
   assign standby_lane = state_r.standby;
   // Lane 0 owns the common-mode buffer, lane 4 the crystal driver.
   assign common_mode_voltage_out = !state_r.standby[0];
   assign crystal_drive_enable    = !state_r.standby[4];

   always_comb begin
      logic [lane_config_pkg::PROFILE_W-1:0] lane_prof;
      lane_prof         = '0;
      lane_filter_sinc5 = '0;
      for (int unsigned n = 0; n < lane_config_pkg::LANES; n++) begin
         lane_prof            = lane_profile(state_r, n);
         lane_filter_sinc5[n] = lane_prof[lane_config_pkg::PROFILE_FILTER_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////
   // Checks.

   // A slot is built from the standby bits of the cycle before data ready rises.
   logic [lane_config_pkg::LANES-1:0] slot_nonzero;
   logic                              repeat_slots_ok;
   always_comb begin
      slot_nonzero    = '0;
      repeat_slots_ok = 1'b1;
      for (int unsigned n = 0; n < lane_config_pkg::LANES; n++) begin
         slot_nonzero[n] = (slot_header[n] != '0) || (slot_data[n] != '0);
         if (slot_header[n][lane_config_pkg::HDR_REPEAT_BIT] && slot_data[n] != '0) begin
            repeat_slots_ok = 1'b0;
         end
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_STANDBY_WRITE: assert property (
      acc_write && paddr == lane_config_pkg::ADDR_CHANNEL_STANDBY_CONTROL
      |=> standby_lane == $past(pwdata[7:0]))
      else $error("standby register did not take the written value");

   AST_STANDBY_SLOT_ZERO: assert property (
      data_ready |-> (slot_nonzero & $past(standby_lane)) == '0)
      else $error("standby lane slot is not all zero");

   AST_VCM_OFF: assert property (
      acc_write && paddr == lane_config_pkg::ADDR_CHANNEL_STANDBY_CONTROL && pwdata[0]
      |=> !common_mode_voltage_out)
      else $error("common-mode output stayed on with lane 0 in standby");

   AST_XTAL_OFF: assert property (
      acc_write && paddr == lane_config_pkg::ADDR_CHANNEL_STANDBY_CONTROL
      |=> crystal_drive_enable == !$past(pwdata[4]))
      else $error("crystal driver does not follow lane 4 standby");

   AST_DRDY_FAST: assert property (
      base_conv_tick && fast_mask == lane_config_pkg::MASK_X32 |=> data_ready)
      else $error("data ready missed at the x32 rate");

   AST_DRDY_ONLY_TICK: assert property (
      data_ready |-> $past(base_conv_tick))
      else $error("data ready without a base tick");

   AST_REPEAT_ZERO: assert property (
      data_ready |-> repeat_slots_ok)
      else $error("repeat slot carries nonzero data");

   AST_PROFILE_UPPER_ZERO: assert property (
      psel && !penable && addr_mapped(paddr) && paddr[3:2] != 2'h0 && paddr[3:2] != 2'h3
      |=> prdata[31:4] == '0)
      else $error("profile upper bits read nonzero");

   AST_RESET_VALUES: assert property (
      $rose(presetn) |-> state_r.prof_a == 4'hD && state_r.prof_b == 4'hD
      && standby_lane == 8'h00 && state_r.pick == 8'h00)
      else $error("register reset values wrong");

   AST_UNMAPPED_ERR: assert property (
      psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
      else $error("unaligned access not refused");

   AST_OUT_OF_RANGE_ERR: assert property (
      psel && penable && paddr[lane_config_pkg::ADDR_W-1:4] != '0 |-> pslverr)
      else $error("access above the register map not refused");

   AST_UNMAPPED_READ_ZERO: assert property (
      psel && !penable && !addr_mapped(paddr)
      |=> prdata == '0)
      else $error("unmapped read returned nonzero data");

   AST_STANDBY_READ: assert property (
      psel && !penable && paddr == lane_config_pkg::ADDR_CHANNEL_STANDBY_CONTROL
      |=> prdata == {24'h00_0000, $past(standby_lane)})
      else $error("standby register read back wrong");

   AST_VCM_ON: assert property (
      acc_write && paddr == lane_config_pkg::ADDR_CHANNEL_STANDBY_CONTROL && !pwdata[0]
      |=> common_mode_voltage_out)
      else $error("common-mode output off with lane 0 enabled");

   AST_PROFILE_A_WRITE: assert property (
      acc_write && paddr == lane_config_pkg::ADDR_PROFILE_A_FILTER_DECIMATION
      |=> state_r.prof_a == $past(pwdata[3:0]))
      else $error("profile A did not take the written value");

   AST_PROFILE_B_WRITE: assert property (
      acc_write && paddr == lane_config_pkg::ADDR_PROFILE_B_FILTER_DECIMATION
      |=> state_r.prof_b == $past(pwdata[3:0]))
      else $error("profile B did not take the written value");

   AST_PICK_WRITE: assert property (
      acc_write && paddr == lane_config_pkg::ADDR_CHANNEL_PROFILE_SELECTOR
      |=> state_r.pick == $past(pwdata[7:0]))
      else $error("profile selector did not take the written value");

   // A write without its low byte strobe must leave every register as it was.
   AST_STROBE_IGNORED: assert property (
      psel && penable && pwrite && !pstrb[0]
      |=> $stable({state_r.standby, state_r.prof_a, state_r.prof_b, state_r.pick}))
      else $error("write without byte strobe changed a register");

   AST_SLOT_HOLD: assert property (
      !data_ready |-> $stable(slot_header) && $stable(slot_data))
      else $error("slots changed without data ready");

   COV_STANDBY_SLOT: cover property (data_ready && standby_lane != 8'h00);
   COV_REPEAT_SLOT: cover property (data_ready && slot_header[0][0]);
   COV_MIXED_PICK: cover property (state_r.pick != 8'h00 && data_ready);
   COV_VCM_OFF: cover property (!common_mode_voltage_out);
   COV_XTAL_OFF: cover property (!crystal_drive_enable);

endmodule

`default_nettype wire

// [test/conv_source.sv]
// Purpose: Converter-side model that paces base ticks and supplies lane results.
// Assumes: Ticks flow only while the bench raises run.
// Notes:   Results carry the lane number plus one, so a misrouted slot shows up.
`timescale 1ns/1ns
`default_nettype none
module conv_source (
   // Clock and reset
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   // Control
   input  wire logic                     run,
   // Converter outputs
   output logic                          base_conv_tick,
   output logic       [7:0][15:0]        conv_result
);
   logic [1:0]  phase_r;
   logic [11:0] smp_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_r <= 2'h0;
         smp_r <= 12'h000;
         base_conv_tick <= 1'b0;
      end else begin
         phase_r <= run ? phase_r + 2'h1 : 2'h0;
         base_conv_tick <= run && (phase_r == 2'h3);
         if (base_conv_tick) begin
            smp_r <= smp_r + 12'h001;
         end
      end
   end

   // Results are only valid with the tick; between ticks they are inverted so that
   // a late sample cannot pass by luck.
   always_comb begin
      for (int n = 0; n < 8; n++) begin
         conv_result[n] = base_conv_tick ? {4'(n + 1), smp_r} : ~{4'(n + 1), smp_r};
      end
   end
endmodule
`default_nettype wire

// [test/lane_config_bench.sv]
// Purpose: Self-checking bench for the lane standby and profile block.
// Assumes: APB answers without wait states, but the master waits for pready anyway.
// Notes:   The stream monitor predicts every slot from its own copy of the registers.
`timescale 1ns/1ns
`default_nettype none
module lane_config_bench;
   logic             pclk, pready, pslverr, base_conv_tick, data_ready, cm_on, xtal_on;
   logic             presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run = 1'b0;
   logic [11:0]      paddr = 12'h000;
   logic [31:0]      pwdata = 32'h0000_0000, prdata;
   logic [3:0]       pstrb = 4'h0;
   logic [7:0][15:0] conv_result, slot_data;
   logic [7:0][7:0]  slot_header;
   logic [7:0]       sinc5, stby_out, stb, pa, pb, sel;
   logic [7:0]       exp_h [8];
   logic [15:0]      exp_d [8];
   logic [4:0]       cnt;
   logic             pend;
   logic [31:0]      tbl [7] = '{32'h000d_0d00, 32'h0000_0bf0, 32'h8101_040f,
                                 32'h00fe_0255, 32'h0007_05aa, 32'hff08_033c, 32'h1000_0000};
   int               err_total = 0, n_compared = 0, cycles = 0;

   lane_config uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .base_conv_tick(base_conv_tick),
      .conv_result(conv_result), .data_ready(data_ready), .slot_header(slot_header),
      .slot_data(slot_data), .common_mode_voltage_out(cm_on), .crystal_drive_enable(xtal_on),
      .lane_filter_sinc5(sinc5), .standby_lane(stby_out));
   conv_source src (.pclk(pclk), .presetn(presetn), .run(run),
      .base_conv_tick(base_conv_tick), .conv_result(conv_result));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic print_verdict;
      if (err_total == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // An idle cycle follows each transfer so psel is never assigned twice in one step.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q, output logic err);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s = 4'h1);
      logic        e;
      logic [31:0] q;
      apb(1'b1, a, {24'h00_0000, d}, s, q, e);
      check("write error", {31'h0, e}, 32'h0000_0000);
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic e_exp);
      logic        e;
      logic [31:0] q;
      apb(1'b0, a, 32'h0000_0000, 4'h0, q, e);
      check("read data", q, exp);
      check("read error", {31'h0, e}, {31'h0, e_exp});
   endtask

   task automatic outs_chk;
      logic [7:0] f;
      for (int n = 0; n < 8; n++) f[n] = sel[n] ? pb[3] : pa[3];
      check("filter pick", {24'h00_0000, sinc5}, {24'h00_0000, f});
      check("standby mirror", {24'h00_0000, stby_out}, {24'h00_0000, stb});
      check("common mode on", {31'h0, cm_on}, {31'h0, !stb[0]});
      check("crystal on", {31'h0, xtal_on}, {31'h0, !stb[4]});
   endtask

   task automatic cfg(input logic [31:0] t);
      {stb, pa, pb, sel} = t & 32'hff0f_0fff;
      wr(12'h000, t[31:24]);
      wr(12'h004, t[23:16]);
      wr(12'h008, t[15:8]);
      wr(12'h00c, t[7:0]);
   endtask

   function automatic logic [4:0] msk(input logic [2:0] c);
      return (c > 3'h4) ? 5'h1f : 5'((1 << c) - 1);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge pclk or negedge presetn) begin : monitor
      logic [4:0] m, fast;
      logic [7:0] h;
      logic [3:0] p;
      if (!presetn) begin
         cnt = 5'h00;
         pend = 1'b0;
      end else begin
         check("ready pulse", {31'h0, data_ready}, {31'h0, pend});
         for (int n = 0; n < 8 && pend; n++) begin
            check("slot header", {24'h0, slot_header[n]}, {24'h0, exp_h[n]});
            check("slot data", {16'h0000, slot_data[n]}, {16'h0000, exp_d[n]});
         end
         pend = 1'b0;
         if (base_conv_tick) begin
            fast = 5'h1f;
            for (int n = 0; n < 8; n++) begin
               p = sel[n] ? pb[3:0] : pa[3:0];
               m = msk(p[2:0]);
               fast = stb[n] ? fast : (fast & m);
               h = {3'h0, p[3], 3'(n), (cnt & m) != m};
               exp_h[n] = stb[n] ? 8'h00 : h;
               exp_d[n] = (stb[n] || h[0]) ? 16'h0000 : conv_result[n];
            end
            pend = (cnt & fast) == fast;
            cnt = cnt + 5'h01;
         end
      end
   end

   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         err_total++;
         print_verdict;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {stb, pa, pb, sel} = 32'h000d_0d00;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      outs_chk;
      rdchk(12'h000, 32'h0000_0000, 1'b0);
      rdchk(12'h004, 32'h0000_000d, 1'b0);
      rdchk(12'h008, 32'h0000_000d, 1'b0);
      rdchk(12'h00c, 32'h0000_0000, 1'b0);
      rdchk(12'h010, 32'h0000_0000, 1'b1);
      rdchk(12'h006, 32'h0000_0000, 1'b1);
      wr(12'h00c, 8'h5a, 4'he);
      rdchk(12'h00c, 32'h0000_0000, 1'b0);
      wr(12'h004, 8'hf6);
      rdchk(12'h004, 32'h0000_0006, 1'b0);
      wr(12'h000, 8'ha5);
      rdchk(12'h000, 32'h0000_00a5, 1'b0);
      for (int i = 0; i < 7; i++) begin
         cfg(tbl[i]);
         outs_chk;
         run <= 1'b1;
         repeat (256) @(posedge pclk);
         run <= 1'b0;
         repeat (4) @(posedge pclk);
      end
      cfg(32'h000d_0d00);
      outs_chk;
      print_verdict;
   end
endmodule
`default_nettype wire
